// ==== src/eaj_pkg.sv ====
// Register map, opcodes, flag positions and cycle counts of the byte arithmetic and jump unit.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package eaj_pkg;
  localparam int         ADDR_W     = 8;
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_OPD    = 8'h04;
  localparam logic [7:0] REG_OPR    = 8'h08;
  localparam logic [7:0] REG_RES    = 8'h0c;
  localparam logic [7:0] REG_FLAGS  = 8'h10;
  localparam logic [7:0] REG_PC     = 8'h14;
  localparam logic [7:0] REG_ZPTR   = 8'h18;
  localparam logic [7:0] REG_STAT   = 8'h1c;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam logic [7:0]  BYTE_ONES  = 8'hff;
  localparam logic [7:0]  BYTE_MIN   = 8'h80;
  localparam logic [7:0]  BYTE_MAX   = 8'h7f;
  localparam logic [15:0] RESET_PC   = 16'h0000;
  localparam logic [1:0]  CNT_ONE    = 2'h0;
  localparam logic [1:0]  CNT_TWO    = 2'h1;
  localparam logic [1:0]  CNT_THREE  = 2'h2;
  localparam logic [4:0] OP_SUM                     = 5'h00;
  localparam logic [4:0] OP_SUM_CARRY               = 5'h01;
  localparam logic [4:0] OP_WORD_PLUS_IMMEDIATE     = 5'h02;
  localparam logic [4:0] OP_WORD_MINUS_IMMEDIATE    = 5'h03;
  localparam logic [4:0] OP_DIFFERENCE              = 5'h04;
  localparam logic [4:0] OP_DIFFERENCE_WITH_BORROW  = 5'h05;
  localparam logic [4:0] OP_MASK                    = 5'h06;
  localparam logic [4:0] OP_MERGE                   = 5'h07;
  localparam logic [4:0] OP_EXCLUSIVE_MERGE         = 5'h08;
  localparam logic [4:0] OP_ONES_INVERT             = 5'h09;
  localparam logic [4:0] OP_TWOS_INVERT             = 5'h0a;
  localparam logic [4:0] OP_SET_MASK_BITS           = 5'h0b;
  localparam logic [4:0] OP_CLEAR_MASK_BITS         = 5'h0c;
  localparam logic [4:0] OP_STEP_UP                 = 5'h0d;
  localparam logic [4:0] OP_STEP_DOWN               = 5'h0e;
  localparam logic [4:0] OP_ZERO_MINUS_CHECK        = 5'h0f;
  localparam logic [4:0] OP_FORCE_ZERO              = 5'h10;
  localparam logic [4:0] OP_FORCE_ONES              = 5'h11;
  localparam logic [4:0] OP_UNSIGNED_PRODUCT        = 5'h12;
  localparam logic [4:0] OP_SIGNED_PRODUCT          = 5'h13;
  localparam logic [4:0] OP_MIXED_SIGN_PRODUCT      = 5'h14;
  localparam logic [4:0] OP_FRACTIONAL_UNSIGNED     = 5'h15;
  localparam logic [4:0] OP_FRACTIONAL_SIGNED       = 5'h16;
  localparam logic [4:0] OP_FRACTIONAL_MIXED        = 5'h17;
  localparam logic [4:0] OP_RELATIVE_GOTO           = 5'h18;
  localparam logic [4:0] OP_POINTER_GOTO            = 5'h19;
  localparam logic [4:0] OP_ABSOLUTE_GOTO           = 5'h1a;
  localparam logic [4:0] OP_RELATIVE_SUBROUTINE_ENTRY = 5'h1b;
  localparam logic [4:0] OP_LAST                    = 5'h1b;
  typedef enum logic {ST_IDLE, ST_EXEC} eaj_state_t;
endpackage : eaj_pkg

// ==== src/eaj_top.sv ====
// Byte arithmetic, product and jump unit behind an AXI4-Lite register slave.
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module eaj_top
  import eaj_pkg::*;
(
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST,
  input  wire logic              I_AWVALID,
  output      logic              O_AWREADY,
  input  wire logic [ADDR_W-1:0] I_AWADDR,
  input  wire logic              I_WVALID,
  output      logic              O_WREADY,
  input  wire logic [31:0]       I_WDATA,
  input  wire logic [3:0]        I_WSTRB,
  output      logic              O_BVALID,
  input  wire logic              I_BREADY,
  output      logic [1:0]        O_BRESP,
  input  wire logic              I_ARVALID,
  output      logic              O_ARREADY,
  input  wire logic [ADDR_W-1:0] I_ARADDR,
  output      logic              O_RVALID,
  input  wire logic              I_RREADY,
  output      logic [31:0]       O_RDATA,
  output      logic [1:0]        O_RRESP
);
  //----------------------------------------------------------------------------
  // Functions
  //----------------------------------------------------------------------------
  // Byte sum returning {half carry, overflow, carry, result}.
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic c);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} + {1'b0, b} + {8'h00, c};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, c};
    return {n[4], (a[7] == b[7]) && (s[7] != a[7]), s[8], s[7:0]};
  endfunction : add8

  // Byte difference returning {half borrow, overflow, borrow, result}.
  function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b,
                                       input logic c);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, a} - {1'b0, b} - {8'h00, c};
    n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
    return {n[4], (a[7] != b[7]) && (s[7] != a[7]), s[8], s[7:0]};
  endfunction : sub8

  // Byte-lane merge of a bus write into a stored word.
  function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : lanes

  // Number of execute cycles minus one for each operation.
  function automatic logic [1:0] op_cnt(input logic [4:0] op);
    logic [1:0] r;
    r = CNT_ONE;
    if ((op == OP_WORD_PLUS_IMMEDIATE) || (op == OP_WORD_MINUS_IMMEDIATE) ||
        ((op >= OP_UNSIGNED_PRODUCT) && (op <= OP_FRACTIONAL_MIXED)) ||
        (op == OP_RELATIVE_GOTO) || (op == OP_POINTER_GOTO)) begin
      r = CNT_TWO;
    end
    if ((op == OP_ABSOLUTE_GOTO) || (op == OP_RELATIVE_SUBROUTINE_ENTRY)) begin
      r = CNT_THREE;
    end
    return r;
  endfunction : op_cnt

  //----------------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------------
  eaj_state_t        state_q, state_d;
  logic [1:0]        cnt_q, cnt_d;
  logic [4:0]        op_q, op_d;
  logic [15:0]       opd_q, opd_d, opr_q, opr_d, res_q, res_d;
  logic [7:0]        flags_q, flags_d;
  logic [15:0]       pc_q, pc_d, zptr_q, zptr_d;
  logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [ADDR_W-1:0] aw_addr_q, aw_addr_d;
  logic [31:0]       w_data_q, w_data_d;
  logic [3:0]        w_strb_q, w_strb_d;
  logic              awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
  logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       rdata_q, rdata_d;
  logic              busy, fin, wr_go, start;
  logic [15:0]       ex_res, ex_pc;
  logic [7:0]        ex_flags;
  logic              ex_wres;

  assign busy  = (state_q == ST_EXEC);
  assign fin   = busy && (cnt_q == CNT_ONE);
  assign wr_go = aw_full_q && w_full_q && !bvalid_q;
  assign start = wr_go && !busy && (aw_addr_q == REG_CMD) && w_strb_q[0] &&
                 (w_data_q[4:0] <= OP_LAST);

  //----------------------------------------------------------------------------
  // Execute datapath
  //----------------------------------------------------------------------------
  // Computes the result, flags and program counter that the last cycle commits.
  always_comb begin : exec_comb
    logic [10:0]        t;
    logic [16:0]        w;
    logic               byte_op, keep_c, keep_h, zkeep;
    logic signed [8:0]  ma, mb;
    logic signed [17:0] pr;
    logic [15:0]        p;
    t        = '0;
    w        = '0;
    byte_op  = 1'b1;
    keep_c   = 1'b1;
    keep_h   = 1'b1;
    zkeep    = 1'b0;
    ma       = '0;
    mb       = '0;
    pr       = '0;
    p        = '0;
    ex_res   = res_q;
    ex_pc    = pc_q;
    ex_flags = flags_q;
    ex_wres  = 1'b1;
    unique case (op_q)
      OP_SUM, OP_SUM_CARRY: begin
        t = add8(opd_q[7:0], opr_q[7:0], (op_q == OP_SUM_CARRY) && flags_q[FLAG_C]);
        keep_c = 1'b0;
        keep_h = 1'b0;
      end
      OP_DIFFERENCE: begin
        t = sub8(opd_q[7:0], opr_q[7:0], 1'b0);
        keep_c = 1'b0;
        keep_h = 1'b0;
      end
      OP_DIFFERENCE_WITH_BORROW: begin
        t = sub8(opd_q[7:0], opr_q[7:0], flags_q[FLAG_C]);
        keep_c = 1'b0;
        keep_h = 1'b0;
        zkeep  = 1'b1;
      end
      OP_MASK:            t = {3'h0, opd_q[7:0] & opr_q[7:0]};
      OP_MERGE:           t = {3'h0, opd_q[7:0] | opr_q[7:0]};
      OP_SET_MASK_BITS:   t = {3'h0, opd_q[7:0] | opr_q[7:0]};
      OP_CLEAR_MASK_BITS: t = {3'h0, opd_q[7:0] & (BYTE_ONES - opr_q[7:0])};
      OP_ZERO_MINUS_CHECK: t = {3'h0, opd_q[7:0] & opd_q[7:0]};
      OP_EXCLUSIVE_MERGE: t = {3'h0, opd_q[7:0] ^ opr_q[7:0]};
      OP_ONES_INVERT: begin
        t = {3'h1, BYTE_ONES - opd_q[7:0]};
        keep_c = 1'b0;
      end
      OP_TWOS_INVERT: begin
        t = sub8(8'h00, opd_q[7:0], 1'b0);
        keep_c = 1'b0;
        keep_h = 1'b0;
      end
      OP_STEP_UP:   t = {1'b0, opd_q[7:0] == BYTE_MAX, 1'b0, opd_q[7:0] + 8'h01};
      OP_STEP_DOWN: t = {1'b0, opd_q[7:0] == BYTE_MIN, 1'b0, opd_q[7:0] - 8'h01};
      OP_FORCE_ZERO: t = '0;
      OP_FORCE_ONES: begin
        byte_op = 1'b0;
        ex_res  = {8'h00, BYTE_ONES};
      end
      OP_WORD_PLUS_IMMEDIATE, OP_WORD_MINUS_IMMEDIATE: begin
        byte_op = 1'b0;
        if (op_q == OP_WORD_PLUS_IMMEDIATE) begin
          w = {1'b0, opd_q} + {9'h000, opr_q[7:0]};
          ex_flags[FLAG_V] = !opd_q[15] && w[15];
          ex_flags[FLAG_C] = opd_q[15] && !w[15];
        end else begin
          w = {1'b0, opd_q} - {9'h000, opr_q[7:0]};
          ex_flags[FLAG_V] = opd_q[15] && !w[15];
          ex_flags[FLAG_C] = !opd_q[15] && w[15];
        end
        ex_res           = w[15:0];
        ex_flags[FLAG_Z] = (w[15:0] == 16'h0000);
        ex_flags[FLAG_N] = w[15];
        ex_flags[FLAG_S] = w[15] ^ ex_flags[FLAG_V];
      end
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_SIGN_PRODUCT,
      OP_FRACTIONAL_UNSIGNED, OP_FRACTIONAL_SIGNED, OP_FRACTIONAL_MIXED: begin
        byte_op = 1'b0;
        ma = {opd_q[7] && (op_q != OP_UNSIGNED_PRODUCT) &&
              (op_q != OP_FRACTIONAL_UNSIGNED), opd_q[7:0]};
        mb = {opr_q[7] && ((op_q == OP_SIGNED_PRODUCT) ||
              (op_q == OP_FRACTIONAL_SIGNED)), opr_q[7:0]};
        pr = ma * mb;
        p  = pr[15:0];
        ex_flags[FLAG_C] = p[15];
        ex_res = (op_q >= OP_FRACTIONAL_UNSIGNED) ? {p[14:0], 1'b0} : p;
        ex_flags[FLAG_Z] = (ex_res == 16'h0000);
      end
      OP_RELATIVE_GOTO, OP_RELATIVE_SUBROUTINE_ENTRY: begin
        byte_op = 1'b0;
        ex_wres = 1'b0;
        ex_pc   = pc_q + {{4{opr_q[11]}}, opr_q[11:0]} + 16'h0001;
      end
      OP_POINTER_GOTO: begin
        byte_op = 1'b0;
        ex_wres = 1'b0;
        ex_pc   = zptr_q;
      end
      OP_ABSOLUTE_GOTO: begin
        byte_op = 1'b0;
        ex_wres = 1'b0;
        ex_pc   = opr_q;
      end
      default: begin
        byte_op = 1'b0;
        ex_wres = 1'b0;
      end
    endcase
    // Common byte flag update; borrow keeps zero only while it was already set.
    if (byte_op) begin
      ex_res           = {8'h00, t[7:0]};
      ex_flags[FLAG_Z] = (t[7:0] == 8'h00) && (!zkeep || flags_q[FLAG_Z]);
      ex_flags[FLAG_N] = t[7];
      ex_flags[FLAG_V] = t[9];
      ex_flags[FLAG_S] = t[7] ^ t[9];
      if (!keep_c) begin
        ex_flags[FLAG_C] = t[8];
      end
      if (!keep_h) begin
        ex_flags[FLAG_H] = t[10];
      end
    end
  end

  //----------------------------------------------------------------------------
  // Bus slave and registers
  //----------------------------------------------------------------------------
  // Next values of the bus channels, the register file and the sequencer.
  always_comb begin : reg_comb
    logic [31:0] wv;
    logic        hit;
    wv = '0;
    hit = 1'b0;
    aw_full_d = aw_full_q || (I_AWVALID && awready_q);
    aw_addr_d = (I_AWVALID && awready_q) ? I_AWADDR : aw_addr_q;
    w_full_d  = w_full_q || (I_WVALID && wready_q);
    w_data_d  = (I_WVALID && wready_q) ? I_WDATA : w_data_q;
    w_strb_d  = (I_WVALID && wready_q) ? I_WSTRB : w_strb_q;
    bvalid_d  = bvalid_q && !I_BREADY;
    bresp_d   = bresp_q;
    state_d   = state_q;
    cnt_d     = busy ? cnt_q - 2'h1 : cnt_q;
    op_d      = op_q;
    opd_d     = opd_q;
    opr_d     = opr_q;
    res_d     = res_q;
    flags_d   = flags_q;
    pc_d      = pc_q;
    zptr_d    = zptr_q;
    if (fin) begin
      state_d = ST_IDLE;
      flags_d = ex_flags;
      pc_d    = ex_pc;
      if (ex_wres) begin
        res_d = ex_res;
      end
    end
    // Writes land only while idle; during execution they are answered but dropped.
    if (wr_go) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      hit = !busy;
      unique case (aw_addr_q)
        REG_CMD: begin
          wv = lanes({27'h0, op_q}, w_data_q, w_strb_q);
          if (start) begin
            op_d    = wv[4:0];
            cnt_d   = op_cnt(wv[4:0]);
            state_d = ST_EXEC;
          end else if (!busy) begin
            bresp_d = RESP_SLVERR;
          end
        end
        REG_OPD: begin
          wv = lanes({16'h0, opd_q}, w_data_q, w_strb_q);
          opd_d = hit ? wv[15:0] : opd_q;
        end
        REG_OPR: begin
          wv = lanes({16'h0, opr_q}, w_data_q, w_strb_q);
          opr_d = hit ? wv[15:0] : opr_q;
        end
        REG_FLAGS: begin
          wv = lanes({24'h0, flags_q}, w_data_q, w_strb_q);
          flags_d = hit ? wv[7:0] : flags_q;
        end
        REG_PC: begin
          wv = lanes({16'h0, pc_q}, w_data_q, w_strb_q);
          pc_d = hit ? wv[15:0] : pc_q;
        end
        REG_ZPTR: begin
          wv = lanes({16'h0, zptr_q}, w_data_q, w_strb_q);
          zptr_d = hit ? wv[15:0] : zptr_q;
        end
        REG_RES, REG_STAT: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
    // Read channel: one read in flight, data registered at the address handshake.
    rvalid_d  = rvalid_q && !I_RREADY;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (I_ARVALID && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = RESP_OKAY;
      unique case (I_ARADDR)
        REG_CMD:   rdata_d = {27'h0, op_q};
        REG_OPD:   rdata_d = {16'h0, opd_q};
        REG_OPR:   rdata_d = {16'h0, opr_q};
        REG_RES:   rdata_d = {16'h0, res_q};
        REG_FLAGS: rdata_d = {24'h0, flags_q};
        REG_PC:    rdata_d = {16'h0, pc_q};
        REG_ZPTR:  rdata_d = {16'h0, zptr_q};
        REG_STAT:  rdata_d = {31'h0, busy};
        default: begin
          rdata_d = '0;
          rresp_d = RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Registers all state.
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state_q <= ST_IDLE;
      cnt_q <= CNT_ONE;
      op_q <= OP_SUM;
      opd_q <= '0;
      opr_q <= '0;
      res_q <= '0;
      flags_q <= '0;
      pc_q <= RESET_PC;
      zptr_q <= '0;
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      opd_q <= opd_d;
      opr_q <= opr_d;
      res_q <= res_d;
      flags_q <= flags_d;
      pc_q <= pc_d;
      zptr_q <= zptr_d;
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q <= w_full_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign O_AWREADY = awready_q;
  assign O_WREADY  = wready_q;
  assign O_BVALID  = bvalid_q;
  assign O_BRESP   = bresp_q;
  assign O_ARREADY = arready_q;
  assign O_RVALID  = rvalid_q;
  assign O_RDATA   = rdata_q;
  assign O_RRESP   = rresp_q;

  //----------------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  sequence s_one;   ##1 fin; endsequence
  sequence s_two;   ##1 (busy && !fin) ##1 fin; endsequence
  sequence s_three; ##1 (busy && !fin) ##1 (busy && !fin) ##1 fin; endsequence

  property p_sum_one;
    start && (w_data_q[4:0] == OP_SUM) |-> s_one;
  endproperty
  a_sum_one: assert property (p_sum_one) else $error("sum not one cycle");
  property p_sum_val;
    fin && (op_q == OP_SUM) |=>
      {flags_q[FLAG_C], res_q[7:0]} == $past({1'b0, opd_q[7:0]} + {1'b0, opr_q[7:0]});
  endproperty
  a_sum_val: assert property (p_sum_val) else $error("sum value wrong");
  property p_word_two;
    start && (w_data_q[4:1] == OP_WORD_PLUS_IMMEDIATE[4:1]) |-> s_two;
  endproperty
  a_word_two: assert property (p_word_two) else $error("word op not two cycles");
  property p_diff_val;
    fin && (op_q == OP_DIFFERENCE) |=> res_q[7:0] == $past(opd_q[7:0] - opr_q[7:0]);
  endproperty
  a_diff_val: assert property (p_diff_val) else $error("difference wrong");
  property p_borrow_val;
    fin && (op_q == OP_DIFFERENCE_WITH_BORROW) |=>
      res_q[7:0] == $past(opd_q[7:0] - opr_q[7:0] - {7'h00, flags_q[FLAG_C]});
  endproperty
  a_borrow_val: assert property (p_borrow_val) else $error("borrow wrong");
  property p_mask_carry;
    fin && (op_q == OP_MASK) |=> $stable(flags_q[FLAG_C]) && !flags_q[FLAG_V];
  endproperty
  a_mask_carry: assert property (p_mask_carry) else $error("mask touched carry");
  property p_clear_bits;
    fin && (op_q == OP_CLEAR_MASK_BITS) |=>
      res_q[7:0] == $past(opd_q[7:0] & ~opr_q[7:0]);
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear bits wrong");
  property p_prod_two;
    start && (w_data_q[4:0] >= OP_UNSIGNED_PRODUCT) &&
      (w_data_q[4:0] <= OP_FRACTIONAL_MIXED) |-> s_two;
  endproperty
  a_prod_two: assert property (p_prod_two) else $error("product not two cycles");
  property p_ptr_goto;
    fin && (op_q == OP_POINTER_GOTO) |=> (pc_q == $past(zptr_q)) && $stable(flags_q);
  endproperty
  a_ptr_goto: assert property (p_ptr_goto) else $error("pointer goto wrong");
  property p_entry_three;
    start && (w_data_q[4:0] == OP_RELATIVE_SUBROUTINE_ENTRY) |-> s_three;
  endproperty
  a_entry_three: assert property (p_entry_three) else $error("entry not three");
  property p_ones;
    fin && (op_q == OP_FORCE_ONES) |=> $stable(flags_q) && (res_q[7:0] == BYTE_ONES);
  endproperty
  a_ones: assert property (p_ones) else $error("force ones wrong");
endmodule : eaj_top

// ==== test/eaj_bus_master.sv ====
// Register bus master model on the far side of the unit.
`timescale 1ns/1ns
module eaj_bus_master
  import eaj_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_awready,
  input  wire logic              i_wready,
  input  wire logic              i_bvalid,
  input  wire logic              i_arready,
  input  wire logic              i_rvalid,
  output      logic              o_awvalid,
  output      logic              o_wvalid,
  output      logic              o_bready,
  output      logic              o_arvalid,
  output      logic              o_rready,
  output      logic [ADDR_W-1:0] o_awaddr,
  output      logic [ADDR_W-1:0] o_araddr,
  output      logic [31:0]       o_wdata
);
  // Idle levels at time zero.
  initial begin
    {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
    {o_awaddr, o_araddr, o_wdata} = '0;
  end
  // One write; each channel is released when taken, and a released payload is inverted.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic aw_q;
    logic w_q;
    aw_q = 1'b1;
    w_q = 1'b1;
    o_awvalid <= 1'b1;
    o_awaddr <= a;
    o_wvalid <= 1'b1;
    o_wdata <= d;
    o_bready <= 1'b1;
    while (aw_q || w_q) begin
      @(posedge i_clk);
      if (aw_q && i_awready) begin
        aw_q = 1'b0;
        o_awvalid <= 1'b0;
        o_awaddr <= ~a;
      end
      if (w_q && i_wready) begin
        w_q = 1'b0;
        o_wvalid <= 1'b0;
        o_wdata <= ~d;
      end
    end
    do @(posedge i_clk); while (!i_bvalid);
    o_bready <= 1'b0;
    // Lets one edge pass so that a following call never reassigns bready in this step.
    @(posedge i_clk);
  endtask : wr
  // One read; rready stays high until the answer is sampled.
  task automatic rd(input logic [ADDR_W-1:0] a);
    o_arvalid <= 1'b1;
    o_araddr <= a;
    o_rready <= 1'b1;
    do @(posedge i_clk); while (!i_arready);
    o_arvalid <= 1'b0;
    o_araddr <= ~a;
    do @(posedge i_clk); while (!i_rvalid);
    o_rready <= 1'b0;
    @(posedge i_clk);
  endtask : rd
endmodule : eaj_bus_master

// ==== test/testbench.sv ====
// Self-checking bench of the arithmetic and jump unit through its register bus.
`timescale 1ns/1ns
module testbench;
  import eaj_pkg::*;
  logic              I_CLK_SYS, I_RST, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [ADDR_W-1:0] aw_a, ar_a;
  logic [31:0]       w_d, r_d;
  logic [1:0]        b_s, r_s;
  logic [15:0]       lfsr_q;
  logic [33:0]       q_exp[$], q_msk[$];
  string             q_nm[$];
  int                fails, n_compared, cyc;
  logic [4:0]        ops[10] = '{OP_SUM, OP_SUM_CARRY, OP_DIFFERENCE, OP_MASK, OP_MERGE,
    OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_ZERO_MINUS_CHECK, OP_UNSIGNED_PRODUCT,
    OP_FRACTIONAL_SIGNED};
  eaj_top dut (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_AWVALID(aw_v), .O_AWREADY(aw_r),
    .I_AWADDR(aw_a), .I_WVALID(w_v), .O_WREADY(w_r), .I_WDATA(w_d), .I_WSTRB(4'hf),
    .O_BVALID(b_v), .I_BREADY(b_r), .O_BRESP(b_s), .I_ARVALID(ar_v), .O_ARREADY(ar_r),
    .I_ARADDR(ar_a), .O_RVALID(r_v), .I_RREADY(r_r), .O_RDATA(r_d), .O_RRESP(r_s));
  eaj_bus_master u_m (.i_clk(I_CLK_SYS), .i_awready(aw_r), .i_wready(w_r), .i_bvalid(b_v),
    .i_arready(ar_r), .i_rvalid(r_v), .o_awvalid(aw_v), .o_wvalid(w_v), .o_bready(b_r),
    .o_arvalid(ar_v), .o_rready(r_r), .o_awaddr(aw_a), .o_araddr(ar_a), .o_wdata(w_d));
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    fails += q_exp.size();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // Compares one read answer or write response, response code included, under a mask.
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] m,
                     input logic [33:0] s);
    n_compared++;
    if ((s & m) !== (e & m)) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e & m, s & m);
    end
  endtask : chk
  // Notes the expected answer, then issues the read.
  task automatic exp_rd(input string nm, input logic [ADDR_W-1:0] a, input logic [33:0] e,
                        input logic [33:0] m);
    q_nm.push_back(nm);
    q_exp.push_back(e);
    q_msk.push_back(m);
    u_m.rd(a);
  endtask : exp_rd
  // Next pseudo-random byte.
  function automatic logic [7:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q[7:0];
  endfunction : rnd
  // Reference result: product or byte in [31:16], flags in [15:8], flag mask in [7:0].
  function automatic logic [31:0] model(input logic [4:0] op, input logic [7:0] d,
                                        input logic [7:0] r, input logic [7:0] f);
    logic [8:0]  s;
    logic [15:0] p;
    logic [7:0]  o;
    logic        ci, c, v, h, pr;
    ci = (op == OP_SUM_CARRY) & f[FLAG_C];
    s = {1'b0, d} + {1'b0, r} + 9'(ci);
    {c, o} = s;
    v = (d[7] == r[7]) && (o[7] != d[7]);
    h = ({1'b0, d[3:0]} + {1'b0, r[3:0]} + 5'(ci)) > 5'h0f;
    pr = (op == OP_UNSIGNED_PRODUCT) || (op == OP_FRACTIONAL_SIGNED);
    p = (op == OP_UNSIGNED_PRODUCT) ? 16'(d * r) : 16'($signed(d) * $signed(r));
    if (op == OP_DIFFERENCE) begin
      o = d - r;
      c = r > d;
      v = (d[7] != r[7]) && (o[7] != d[7]);
      h = r[3:0] > d[3:0];
    end else if (!pr && op != OP_SUM && op != OP_SUM_CARRY) begin
      o = (op == OP_MASK) ? d & r : (op == OP_ZERO_MINUS_CHECK) ? d :
          (op == OP_CLEAR_MASK_BITS) ? d & (8'hff - r) : d | r;
      {c, v, h} = {f[FLAG_C], 1'b0, f[FLAG_H]};
    end
    if (pr) begin
      c = p[15];
      p = (op == OP_FRACTIONAL_SIGNED) ? p << 1 : p;
      return {p, f[7:6], h, f[4], v, o[7], p == 16'h0000, c, 8'h03};
    end
    return {8'h00, o, f[7:6], h, f[4], v, o[7], o == 8'h00, c, 8'h2f};
  endfunction : model
  // Starts one operation and waits until it has finished.
  task automatic go(input logic [4:0] op);
    u_m.wr(REG_CMD, {27'h0, op});
    repeat (3) @(posedge I_CLK_SYS);
  endtask : go
  // Runs one operation and checks its result and flags.
  task automatic run(input logic [4:0] op, input logic [7:0] d, input logic [7:0] r,
                     input logic [7:0] f);
    logic [31:0] e;
    e = model(op, d, r, f);
    u_m.wr(REG_OPD, {24'h0, d});
    u_m.wr(REG_OPR, {24'h0, r});
    u_m.wr(REG_FLAGS, {24'h0, f});
    go(op);
    exp_rd("result", REG_RES, {18'h0, e[31:16]}, {2'h3, 32'h0000ffff});
    exp_rd("flags", REG_FLAGS, {26'h0, e[15:8]}, {2'h3, 24'h0, e[7:0]});
    $display("done op %h", op);
  endtask : run
  // Clock at 125 MHz.
  initial begin
    I_CLK_SYS = 1'b0;
    forever #4 I_CLK_SYS = ~I_CLK_SYS;
  end
  // Watcher: each read answer is compared with the oldest note.
  always @(posedge I_CLK_SYS) begin
    cyc <= cyc + 1;
    if (r_v && r_r && q_exp.size() > 0) begin
      chk(q_nm.pop_front(), q_exp.pop_front(), q_msk.pop_front(), {r_s, r_d});
    end
    // Every write that the bench issues is legal, so each response must be OKAY.
    if (b_v && b_r) begin
      chk("bresp", {RESP_OKAY, 32'h0}, {2'h3, 32'h0}, {b_s, 32'h0});
    end
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  // Main sequence.
  initial begin
    {I_RST, lfsr_q} = {1'b1, 16'h0034};
    repeat (4) @(posedge I_CLK_SYS);
    I_RST <= 1'b0;
    repeat (2) @(posedge I_CLK_SYS);
    exp_rd("pc", REG_PC, 34'h0, 34'h3ffffffff);
    exp_rd("unmapped", 8'h20, {RESP_SLVERR, 32'h0}, {2'h3, 32'h0});
    run(OP_SUM, 8'hff, 8'h01, 8'h00);
    run(OP_SUM_CARRY, 8'h7f, 8'h00, 8'h01);
    run(OP_DIFFERENCE, 8'h80, 8'h01, 8'h00);
    run(OP_MASK, 8'hf0, 8'h0f, 8'h21);
    repeat (4) foreach (ops[i]) begin
      run(ops[i], rnd(), rnd(), rnd());
    end
    u_m.wr(REG_OPD, 32'h0000_00ff);
    u_m.wr(REG_OPR, 32'h0000_0001);
    go(OP_WORD_PLUS_IMMEDIATE);
    exp_rd("word", REG_RES, 34'h0100, 34'h3ffffffff);
    u_m.wr(REG_FLAGS, 32'h0000_0001);
    go(OP_DIFFERENCE_WITH_BORROW);
    exp_rd("borrow", REG_RES, 34'h00fd, 34'h3ffffffff);
    go(OP_FORCE_ONES);
    exp_rd("ones", REG_RES, 34'h00ff, 34'h3ffffffff);
    $display("done word, borrow and ones");
    u_m.wr(REG_PC, 32'h0000_1000);
    u_m.wr(REG_OPR, 32'h0000_0ffe);
    u_m.wr(REG_FLAGS, 32'h0000_00a5);
    go(OP_RELATIVE_GOTO);
    exp_rd("pc", REG_PC, 34'h0fff, 34'h3ffffffff);
    u_m.wr(REG_ZPTR, 32'h0000_beef);
    go(OP_POINTER_GOTO);
    exp_rd("pc", REG_PC, 34'hbeef, 34'h3ffffffff);
    exp_rd("flags", REG_FLAGS, 34'ha5, 34'h3ffffffff);
    go(OP_RELATIVE_SUBROUTINE_ENTRY);
    exp_rd("pc", REG_PC, 34'hbeee, 34'h3ffffffff);
    go(OP_ABSOLUTE_GOTO);
    exp_rd("pc", REG_PC, 34'h0ffe, 34'h3ffffffff);
    $display("done jumps");
    repeat (4) @(posedge I_CLK_SYS);
    finish_test();
  end
endmodule : testbench
